/* rtl/ijls_top.sv */
// Purpose: Program sequencer with indirect jump, lookup and serial exchange.
// Assumes: ROM answers combinationally to ROM_ADDR_O within one core cycle.
// Notes:   All sequencing happens on the instruction tick.
`timescale 1ns/1ps
`include "ijls_consts.svh"

module ijls_top
(
    input  wire logic                CORE_CLK_I,
    input  wire logic                RST_I,
    input  wire logic [1:0]          CLK_SEL_I,
    input  wire logic [7:0]          ROM_DATA_I,
    input  wire ijls_pkg::ijls_data_t DATA_I,
    input  wire logic [3:0]          EN_I,
    input  wire logic                SKIP_I,
    input  wire logic                CARRY_I,
    input  wire logic                SI_PIN_I,
    input  wire logic                SO_PIN_I,
    output logic      [8:0]          ROM_ADDR_O,
    output logic      [7:0]          Q_O,
    output logic      [3:0]          ACC_O,
    output logic                     ACC_WE_O,
    output logic                     SER_CLK_O,
    output logic                     SO_O,
    output logic      [7:0]          INSTR_O,
    output logic                     EXEC_O,
    output logic                     TEST_RAM_O,
    output logic                     TEST_ROM_O
);
    import ijls_pkg::*;

    // ****************************************
    // Instruction clock divider
    // ****************************************
    logic [2:0]  cnt_reg;
    logic [2:0]  cnt_next;
    wire  [2:0]  div_last;
    wire         tick;
    wire         sclk_phase;

    assign div_last = (CLK_SEL_I == `IJLS_SEL_XTAL) ? `IJLS_DIV8_LAST : `IJLS_DIV4_LAST;
    assign tick     = (cnt_reg >= div_last);
    assign cnt_next = tick ? 3'h0 : cnt_reg + 3'h1;
    assign sclk_phase = (cnt_reg <= {1'b0, div_last[2:1]});

    always_ff @(posedge CORE_CLK_I)
    begin
        if (RST_I)
            cnt_reg <= 3'h0;
        else
            cnt_reg <= cnt_next;
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0]  si_sync_reg;
    logic [2:0]  so_sync_reg;
    logic        si_st_reg;
    logic        so_st_reg;
    logic        si_st_next;
    logic        so_st_next;

    // A change counts only once the second and third stages agree.
    assign si_st_next = (si_sync_reg[1] == si_sync_reg[2]) ? si_sync_reg[2] : si_st_reg;
    assign so_st_next = (so_sync_reg[1] == so_sync_reg[2]) ? so_sync_reg[2] : so_st_reg;

    always_ff @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            si_sync_reg <= 3'h0;
            so_sync_reg <= 3'h0;
            si_st_reg   <= 1'b0;
            so_st_reg   <= 1'b0;
        end
        else
        begin
            si_sync_reg <= {si_sync_reg[1:0], SI_PIN_I};
            so_sync_reg <= {so_sync_reg[1:0], SO_PIN_I};
            si_st_reg   <= si_st_next;
            so_st_reg   <= so_st_next;
        end
    end

    // ****************************************
    // Instruction decode
    // ****************************************
    ijls_state_t st_reg;
    ijls_state_t st_next;
    logic [8:0]  pc_reg;
    logic [8:0]  pc_next;
    logic [8:0]  stk_up_reg;
    logic [8:0]  up_next;
    logic [8:0]  stk_lo_reg;
    logic [8:0]  lo_next;
    logic        skip_reg;
    logic        skip_next;
    logic [7:0]  op_reg;
    logic        opsk_reg;
    logic        opsk_next;
    logic        kind_reg;
    logic        kind_next;
    wire  [7:0]  op;
    wire  [8:0]  pc_inc;
    wire  [8:0]  ind_addr;
    wire         is_long;
    wire         in_sub;
    wire         is_jmp;
    wire         is_jsr;
    wire         ex;
    wire         ex_xchg;
    wire         ex_ijump;
    wire         ex_lq;
    wire         ex_retskp;
    wire         exec_next;

    assign op       = ROM_DATA_I;
    assign pc_inc   = pc_reg + `IJLS_PC_ONE;
    assign ind_addr = {pc_inc[8], DATA_I.acc, DATA_I.ram};
    assign is_long  = (op == `IJLS_OP_PFX) || (op[7:4] == `IJLS_HI_LONG);
    // group field is PC bits 8 to 7.
    assign in_sub   = (pc_inc[8:7] == `IJLS_SUB_GRP);
    assign is_jmp   = (op_reg[7:4] == `IJLS_HI_LONG) && (op_reg[3:1] == `IJLS_JMP_SEL);
    assign is_jsr   = (op_reg[7:4] == `IJLS_HI_LONG) && (op_reg[3:1] == `IJLS_JSR_SEL);
    assign ex       = tick && (st_reg == ST_EXEC) && !skip_reg;
    assign ex_xchg   = ex && (op == `IJLS_OP_XCHG);
    assign ex_ijump  = ex && (op == `IJLS_OP_IJUMP);
    assign ex_lq     = ex && (op == `IJLS_OP_LOOKUP);
    assign ex_retskp = ex && (op == `IJLS_OP_RETSKP);
    assign exec_next = ex || (tick && (st_reg == ST_OPER) && !opsk_reg);

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb
    begin
        st_next   = st_reg;
        pc_next   = pc_reg;
        up_next   = stk_up_reg;
        lo_next   = stk_lo_reg;
        skip_next = skip_reg;
        opsk_next = opsk_reg;
        kind_next = kind_reg;
        unique case (st_reg)
            ST_EXEC:
            begin
                pc_next = pc_inc;
                // skipped bytes cost one cycle each.
                if (skip_reg)
                begin
                    skip_next = 1'b0;
                    if (is_long)
                    begin
                        st_next   = ST_OPER;
                        opsk_next = 1'b1;
                    end
                end
                else if (op == `IJLS_OP_IJUMP)
                begin
                    pc_next   = ind_addr;
                    st_next   = ST_IND;
                    kind_next = 1'b0;
                end
                else if (op == `IJLS_OP_LOOKUP)
                begin
                    up_next   = pc_inc;
                    lo_next   = stk_up_reg;
                    pc_next   = ind_addr;
                    st_next   = ST_IND;
                    kind_next = 1'b1;
                end
                else if ((op == `IJLS_OP_RET) || (op == `IJLS_OP_RETSKP))
                begin
                    pc_next   = stk_up_reg;
                    up_next   = stk_lo_reg;
                    skip_next = (op == `IJLS_OP_RETSKP);
                end
                else if (is_long)
                begin
                    st_next   = ST_OPER;
                    opsk_next = 1'b0;
                end
                else if (op[7] && in_sub)
                    pc_next = {pc_inc[8:7], op[6:0]};
                else if (op[7] && op[6])
                    pc_next = {pc_inc[8:6], op[5:0]};
                else if (op[7])
                begin
                    up_next = pc_inc;
                    lo_next = stk_up_reg;
                    pc_next = {`IJLS_SUB_PAGE, op[5:0]};
                end
                else
                    skip_next = SKIP_I;
            end
            ST_OPER:
            begin
                st_next = ST_EXEC;
                pc_next = pc_inc;
                if (!opsk_reg && is_jmp)
                    pc_next = {op_reg[0], op};
                else if (!opsk_reg && is_jsr)
                begin
                    up_next = pc_inc;
                    lo_next = stk_up_reg;
                    pc_next = {op_reg[0], op};
                end
                else if (!opsk_reg)
                    skip_next = SKIP_I;
            end
            ST_IND:
            begin
                st_next = ST_EXEC;
                if (kind_reg)
                begin
                    pc_next = stk_up_reg;
                    up_next = stk_lo_reg;
                end
                else
                    pc_next = {pc_reg[8], op};
            end
            default:
                st_next = ST_EXEC;
        endcase
    end

    // two cycles for jump and lookup.
    always_ff @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            st_reg     <= ST_EXEC;
            pc_reg     <= `IJLS_PC_RST;
            stk_up_reg <= `IJLS_PC_RST;
            stk_lo_reg <= `IJLS_PC_RST;
            skip_reg   <= 1'b0;
            opsk_reg   <= 1'b0;
            kind_reg   <= 1'b0;
            op_reg     <= 8'h00;
        end
        else if (tick)
        begin
            st_reg     <= st_next;
            pc_reg     <= pc_next;
            stk_up_reg <= up_next;
            stk_lo_reg <= lo_next;
            skip_reg   <= skip_next;
            opsk_reg   <= opsk_next;
            kind_reg   <= kind_next;
            op_reg     <= op;
        end
    end

    // ****************************************
    // Serial register and output latches
    // ****************************************
    logic [3:0]  ser_reg;
    logic [3:0]  ser_next;
    logic        sclk_lat_reg;
    logic        si_old_reg;
    wire         shift_mode;
    wire         si_fall;

    // enable bit picks shift or count.
    assign shift_mode = EN_I[`IJLS_EN_SHIFT];
    assign si_fall    = si_old_reg && !si_st_reg;
    // exchange wins over shift or count.
    assign ser_next   = ex_xchg ? DATA_I.acc :
                        (shift_mode && tick) ? {ser_reg[2:0], si_st_reg} :
                        (!shift_mode && si_fall) ? ser_reg + 4'h1 : ser_reg;

    always_ff @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            ser_reg     <= 4'h0;
            si_old_reg  <= 1'b0;
            sclk_lat_reg <= 1'b0;
            ROM_ADDR_O  <= `IJLS_PC_RST;
            Q_O         <= 8'h00;
            ACC_O       <= 4'h0;
            ACC_WE_O    <= 1'b0;
            SER_CLK_O   <= 1'b0;
            SO_O        <= 1'b0;
            INSTR_O     <= 8'h00;
            EXEC_O      <= 1'b0;
            TEST_RAM_O  <= 1'b0;
            TEST_ROM_O  <= 1'b0;
        end
        else
        begin
            ser_reg     <= ser_next;
            si_old_reg  <= si_st_reg;
            ROM_ADDR_O  <= tick ? pc_next : ROM_ADDR_O;
            ACC_WE_O    <= ex_xchg;
            EXEC_O      <= exec_next;
            if (ex_xchg)
                ACC_O <= ser_reg;
            if (ex_xchg)
                sclk_lat_reg <= CARRY_I;
            SER_CLK_O   <= shift_mode ? (sclk_lat_reg && sclk_phase) : sclk_lat_reg;
            SO_O        <= shift_mode && ser_reg[3];
            if (exec_next)
                INSTR_O <= op;
            if (tick && (st_reg == ST_IND) && kind_reg)
                Q_O <= op;
            TEST_RAM_O  <= so_st_reg && si_st_reg;
            TEST_ROM_O  <= so_st_reg && !si_st_reg;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_xchg;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        ex_xchg |=> (ser_reg == $past(DATA_I.acc)) && (ACC_O == $past(ser_reg)) && ACC_WE_O;
    endproperty
    a_xchg: assert property (p_xchg) else $error("exchange failed");

    property p_div;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        tick |=> !tick [*3];
    endproperty
    a_div: assert property (p_div) else $error("tick too close");

    // The jump's own pulse stands first; the second cycle brings no pulse.
    property p_ijump_two;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        ex_ijump |=> (st_reg == ST_IND) && EXEC_O ##1 !EXEC_O ##[2:6] tick
            ##1 (st_reg == ST_EXEC) && !EXEC_O;
    endproperty
    a_ijump_two: assert property (p_ijump_two) else $error("jump length wrong");

    property p_ijump_pc;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        tick && (st_reg == ST_IND) && !kind_reg |=>
            (pc_reg[7:0] == $past(op)) && (pc_reg[8] == $past(pc_reg[8]));
    endproperty
    a_ijump_pc: assert property (p_ijump_pc) else $error("jump target wrong");

    property p_lq_q;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        tick && (st_reg == ST_IND) && kind_reg |=>
            (Q_O == $past(op)) && (pc_reg == $past(stk_up_reg));
    endproperty
    a_lq_q: assert property (p_lq_q) else $error("lookup latch wrong");

    property p_lq_stack;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        tick && (st_reg == ST_IND) && kind_reg |=> (stk_up_reg == stk_lo_reg);
    endproperty
    a_lq_stack: assert property (p_lq_stack) else $error("lookup stack wrong");

    property p_skip;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        tick && (st_reg == ST_EXEC) && skip_reg |=> (pc_reg == $past(pc_inc)) && !EXEC_O;
    endproperty
    a_skip: assert property (p_skip) else $error("skip wrong");

    property p_retskp;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        ex_retskp |=> skip_reg && (pc_reg == $past(stk_up_reg));
    endproperty
    a_retskp: assert property (p_retskp) else $error("return skip wrong");

    property p_test;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        so_st_reg && si_st_reg |=> TEST_RAM_O && !TEST_ROM_O;
    endproperty
    a_test: assert property (p_test) else $error("test mode wrong");

endmodule // ijls_top

/* rtl/ijls_consts.svh */
// Purpose: Constants for the indirect jump and lookup sequencer.
// Assumes: Included by the sequencer top.
// Notes:   Opcodes, field positions, reset values and divider counts.
`ifndef IJLS_CONSTS_SVH
`define IJLS_CONSTS_SVH

`define IJLS_OP_IJUMP   8'hFF
`define IJLS_OP_LOOKUP  8'hBF
`define IJLS_OP_RET     8'h48
`define IJLS_OP_RETSKP  8'h49
`define IJLS_OP_XCHG    8'h4F
`define IJLS_OP_PFX     8'h33
`define IJLS_HI_LONG    4'h6
`define IJLS_JMP_SEL    3'h0
`define IJLS_JSR_SEL    3'h4
`define IJLS_SUB_PAGE   3'h2
`define IJLS_SUB_GRP    2'h1
`define IJLS_PC_RST     9'h000
`define IJLS_PC_ONE     9'h001
`define IJLS_EN_SHIFT   0
`define IJLS_SEL_XTAL   2'h0
`define IJLS_DIV8_LAST  3'h7
`define IJLS_DIV4_LAST  3'h3

`endif

/* rtl/ijls_pkg.sv */
// Purpose: Types shared by the sequencer.
// Assumes: Nothing beyond the constants header.
// Notes:   Gray codes along the usual state path.
package ijls_pkg;

    typedef enum logic [1:0]
    {
        ST_EXEC = 2'h0,
        ST_OPER = 2'h1,
        ST_IND  = 2'h2
    } ijls_state_t;

    typedef struct packed
    {
        logic [3:0] acc;
        logic [3:0] ram;
    } ijls_data_t;

endpackage

/* testbench/ijls_rom_model.sv */
// Purpose: Program ROM model facing the sequencer's instruction bus.
// Assumes: The sequencer samples the byte at its instruction tick.
// Notes:   The bench loads the image before reset is released.
`timescale 1ns/1ps

module ijls_rom_model
#(
    parameter logic [7:0] CLR_ACC_OP = 8'h00
)
(
    input  wire logic [8:0] addr_i,
    output logic      [7:0] data_o
);
    // ****************************************
    // Storage
    // ****************************************
    // eight pages of 64
    localparam int PAGES = 8;
    localparam int WORDS = 64;

    logic [7:0] mem [0:PAGES*WORDS-1];

    initial mem[0] = CLR_ACC_OP;

    // The answer is combinational, so no stale byte survives an address change.
    assign data_o = mem[addr_i];

endmodule // ijls_rom_model

/* testbench/ijls_top_tb.sv */
// Purpose: Self-checking bench for the sequencer.
// Assumes: One tick every 8 or 4 core cycles after reset.
// Notes:   A driver notes expectations, a monitor compares them.
`timescale 1ns/1ps

module ijls_top_tb;
    import ijls_pkg::*;

    typedef struct
    {
        logic [8:0] addr;
        logic [1:0] exec;
        logic [7:0] op;
        logic       we;
        logic [3:0] acc;
        logic [7:0] q;
        logic [1:0] sclk;
    } ijls_exp_t;

    logic       core_clk;
    logic       rst;
    logic       skip;
    logic       carry;
    logic       si_pin;
    logic       so_pin;
    logic [1:0] clk_sel;
    logic [3:0] en;
    ijls_data_t data;
    logic [8:0] rom_addr;
    logic [7:0] rom_data;
    logic [7:0] q;
    logic [7:0] instr;
    logic [3:0] acc;
    logic       acc_we;
    logic       sclk;
    logic       so;
    logic       exec;
    logic       t_ram;
    logic       t_rom;
    logic [3:0] r [12];
    logic [7:0] q_exp;
    int         n_mismatch = 0;
    int         checks = 0;
    int         tcnt = 0;
    int         last;
    ijls_exp_t  exq [$];

    ijls_top ijls_top_i
    (
        .CORE_CLK_I (core_clk),
        .RST_I      (rst),
        .CLK_SEL_I  (clk_sel),
        .ROM_DATA_I (rom_data),
        .DATA_I     (data),
        .EN_I       (en),
        .SKIP_I     (skip),
        .CARRY_I    (carry),
        .SI_PIN_I   (si_pin),
        .SO_PIN_I   (so_pin),
        .ROM_ADDR_O (rom_addr),
        .Q_O        (q),
        .ACC_O      (acc),
        .ACC_WE_O   (acc_we),
        .SER_CLK_O  (sclk),
        .SO_O       (so),
        .INSTR_O    (instr),
        .EXEC_O     (exec),
        .TEST_RAM_O (t_ram),
        .TEST_ROM_O (t_rom)
    );

    ijls_rom_model ijls_rom_model_i
    (
        .addr_i (rom_addr),
        .data_o (rom_data)
    );

    // ****************************************
    // Clock and tick tracking
    // ****************************************
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    assign last = (clk_sel == 2'h0) ? 7 : 3;

    always @(posedge core_clk)
        if (rst)
            tcnt <= 0;
        else
            tcnt <= (tcnt == last) ? 0 : tcnt + 1;

    // ****************************************
    // Checking
    // ****************************************
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] want);
        checks++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic give_verdict();
        if (n_mismatch == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Pulses stand in the core cycle after the tick; the clock latch shows a cycle later.
    always @(negedge core_clk)
        if (!rst && tcnt == 0 && exq.size() > 0)
        begin
            ijls_exp_t e;
            e = exq.pop_front();
            check("rom_addr", rom_addr, e.addr);
            check("q_latch", 9'(q), 9'(e.q));
            if (e.exec != 2'h2) check("exec", 9'(exec), 9'(e.exec));
            if (e.exec == 2'h1) check("instr", 9'(instr), 9'(e.op));
            check("acc_we", 9'(acc_we), 9'(e.we));
            if (e.we) check("acc", 9'(acc), 9'(e.acc));
            @(negedge core_clk);
            if (e.sclk != 2'h2) check("sclk", 9'(sclk), 9'(e.sclk));
        end

    // ****************************************
    // Driving
    // ****************************************
    task automatic step(input logic [7:0] op, input logic [8:0] nxt,
                        input logic [1:0] ex = 2'h1, input logic [3:0] a = 4'h0,
                        input logic [3:0] m = 4'h0, input logic skc = 1'b0,
                        input logic e0 = 1'b0, input logic c = 1'b0,
                        input logic we = 1'b0, input logic [3:0] xa = 4'h0,
                        input logic [1:0] sce = 2'h2);
        @(negedge core_clk);
        while (tcnt != last)
            @(negedge core_clk);
        data.acc = a;
        data.ram = m;
        skip = skc;
        en = {3'h0, e0};
        carry = c;
        exq.push_back('{nxt, ex, op, we, xa, q_exp, sce});
    endtask

    task automatic do_reset(input logic [1:0] sel);
        @(negedge core_clk);
        rst = 1'b1;
        clk_sel = sel;
        q_exp = 8'h00;
        repeat (8) @(negedge core_clk);
        rst = 1'b0;
        check("reset_addr", rom_addr, 9'h000);
        check("reset_q", 9'(q), 9'h000);
    endtask

    initial
    begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        give_verdict();
    end

    initial
    begin
        logic [7:0] img [20];
        img = '{8'h00, 8'h4F, 8'h4F, 8'h4F, 8'h00, 8'h00, 8'h00, 8'h4F, 8'h00, 8'hFF,
                8'h00, 8'h33, 8'h3E, 8'h00, 8'hBF, 8'h68, 8'h40, 8'h49, 8'h60, 8'hFF};
        {rst, skip, carry, si_pin, so_pin, clk_sel, en, data} = '0;
        q_exp = 8'h00;
        void'($urandom(32'hDEDBC7FD));
        for (int i = 0; i < 12; i++)
            r[i] = 4'($urandom);
        r[6] = r[6] & 4'h7;
        for (int i = 1; i < 512; i++)
            ijls_rom_model_i.mem[i] = 8'($urandom);
        for (int i = 1; i < 20; i++)
            ijls_rom_model_i.mem[i] = img[i];
        ijls_rom_model_i.mem[{1'b1, r[6], r[7]}] = 8'hBE;
        ijls_rom_model_i.mem[9'h040] = 8'hBF;
        ijls_rom_model_i.mem[9'h041] = 8'h48;
        ijls_rom_model_i.mem[9'h0FF] = 8'hFF;
        ijls_rom_model_i.mem[9'h1BE] = 8'h00;
        ijls_rom_model_i.mem[9'h1BF] = 8'hBF;
        ijls_rom_model_i.mem[9'h1C0] = 8'h61;
        ijls_rom_model_i.mem[9'h1C1] = 8'hFF;
        ijls_rom_model_i.mem[9'h1FF] = 8'hFF;
        do_reset(2'h0);
        step(8'h00, 9'h001);
        step(8'h4F, 9'h002, 2'h1, r[0], 4'h0, 1'b0, 1'b0, 1'b1, 1'b1, 4'h0, 2'h1);
        step(8'h4F, 9'h003, 2'h1, r[1], 4'h0, 1'b0, 1'b0, 1'b0, 1'b1, r[0], 2'h0);
        // shift mode, exchange every fourth cycle
        step(8'h4F, 9'h004, 2'h1, r[2], 4'h0, 1'b0, 1'b1, 1'b0, 1'b1, r[1]);
        for (int i = 5; i < 8; i++)
            step(8'h00, 9'(i), 2'h1, 4'h0, 4'h0, 1'b0, 1'b1);
        step(8'h4F, 9'h008, 2'h1, r[3], 4'h0, 1'b0, 1'b1, 1'b0, 1'b1, {r[2][0], 3'h0});
        // skipped bytes take one cycle each
        step(8'h00, 9'h009, 2'h1, 4'h0, 4'h0, 1'b1);
        step(8'hFF, 9'h00A, 2'h0);
        step(8'h00, 9'h00B, 2'h1, 4'h0, 4'h0, 1'b1);
        step(8'h33, 9'h00C, 2'h0);
        step(8'h3E, 9'h00D, 2'h0);
        step(8'h00, 9'h00E, 2'h1, 4'h0, 4'h0, 1'b1);
        step(8'hBF, 9'h00F, 2'h0);
        step(8'h68, 9'h010);
        step(8'h40, 9'h040, 2'h2);
        step(8'hBF, {1'b0, r[4], r[5]}, 2'h1, r[4], r[5]);
        q_exp = ijls_rom_model_i.mem[{1'b0, r[4], r[5]}];
        step(8'h00, 9'h041, 2'h2);
        step(8'h48, 9'h011);
        step(8'h49, 9'h011);
        step(8'h49, 9'h012, 2'h0);
        step(8'h60, 9'h013);
        step(8'hFF, 9'h0FF, 2'h2);
        step(8'hFF, {1'b1, r[6], r[7]}, 2'h1, r[6], r[7]);
        step(8'h00, 9'h1BE, 2'h2);
        step(8'h00, 9'h1BF);
        step(8'hBF, {1'b1, r[8], r[9]}, 2'h1, r[8], r[9]);
        q_exp = ijls_rom_model_i.mem[{1'b1, r[8], r[9]}];
        step(8'h00, 9'h1C0, 2'h2);
        step(8'h61, 9'h1C1);
        step(8'hFF, 9'h1FF, 2'h2);
        // page seven wraps to group zero
        step(8'hFF, {1'b0, r[10], r[11]}, 2'h1, r[10], r[11]);
        step(8'h00, {1'b0, ijls_rom_model_i.mem[{1'b0, r[10], r[11]}]}, 2'h2);
        repeat (16) @(negedge core_clk);
        // divide by four after a second reset
        do_reset(2'h1);
        step(8'h00, 9'h001);
        step(8'h4F, 9'h002, 2'h1, r[3], 4'h0, 1'b0, 1'b0, 1'b1, 1'b1, 4'h0, 2'h1);
        repeat (8) @(negedge core_clk);
        for (int k = 0; k < 3; k++)
        begin
            so_pin = (k != 2);
            si_pin = (k == 0);
            repeat (8) @(negedge core_clk);
            check("test_ram", 9'(t_ram), 9'(k == 0));
            check("test_rom", 9'(t_rom), 9'(k == 1));
            check("ser_out", 9'(so), 9'h000);
        end
        give_verdict();
    end

endmodule // ijls_top_tb
